// ---- hdl/ptd_pkg.sv ----
// Package: register map, field layout, select codes and state encoding of the trigger delay unit
// What this block does
// [RULE_01] Counter ticks at bus clock divided by 1..128, prescale code 000..111.
// [RULE_02] First output select: bypass, delay A, both delays, or shaped pulse.
// [RULE_03] Second output select uses the same four-way encoding.
// [RULE_04] Repeat mode bit 0 gives one-shot, 1 gives continuous counting.
// [RULE_05] Soft kick with selector 7 and unit enabled restarts the counter.
// [RULE_06] In bypass a soft kick reaches the output as one-cycle pulse.
// [RULE_07] The soft kick bit always reads as zero.
// [RULE_08] Three-bit selector picks comparators, PWM sync, pin, timers or soft kick.
// [RULE_09] First enable clear forces first output low and stops its comparator.
// [RULE_10] Second enable clear forces second output low and stops its comparator.
// [RULE_11] Counter runs only while at least one enable bit is set.
// [RULE_12] Software sets both enables before using shaped pulse mode.
// [RULE_13] Delays apply only when enabled and the output is not bypassed.
// [RULE_14] Counter clears at the period value; continuous mode keeps counting.
// [RULE_15] Count register reads the live counter; writes are ignored.
// [RULE_16] A new input event before the count ends restarts the counter.
// [RULE_17] Both outputs come from flip-flops and never glitch.
// [RULE_18] A fast-domain PWM sync pulse is still detected reliably; the code samples once per bus clock, assuming the pulse is stretched.
// [RULE_19] Software picks the smallest divisor; resolution equals the divisor.
// [RULE_20] The unit has no interrupt output.
// [RULE_21] One reset input, the device reset, initialises everything.
// [RULE_22] A rising edge of the selected input starts the counter from zero.
// [RULE_23] Early event at divisor*delay+1 clocks; output one clock later.
// [RULE_24] One-shot mode stops after the wrap until the next input event.
// [RULE_25] Shaped pulse rises on first early event, falls on second.
// [RULE_26] Both-delays selection ORs the two delay pulses, two triggers per start.
// [RULE_27] Delayed outputs pulse one clock wide; all fields reset to zero.
package ptd_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [2:0] REG_CTRL_IDX   = 3'h0;
    localparam logic [2:0] REG_DELAYA_IDX = 3'h1;
    localparam logic [2:0] REG_DELAYB_IDX = 3'h2;
    localparam logic [2:0] REG_PERIOD_IDX = 3'h3;
    localparam logic [2:0] REG_COUNT_IDX  = 3'h4;
    // Control register field positions
    localparam int PRESCALE_LSB = 13;
    localparam int FIRST_SEL_LSB = 10;
    localparam int SECOND_SEL_LSB = 7;
    localparam int REPEAT_BIT = 6;
    localparam int KICK_BIT = 5;
    localparam int EVENT_SEL_LSB = 2;
    localparam int FIRST_EN_BIT = 1;
    localparam int SECOND_EN_BIT = 0;
    // Writable control bits; reserved 12, 9 and kick bit read zero
    localparam logic [15:0] CTRL_RW_MASK = 16'hEDDF;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Output select codes
    localparam logic [1:0] SEL_BYPASS = 2'h0;
    localparam logic [1:0] SEL_DELAY_A = 2'h1;
    localparam logic [1:0] SEL_BOTH = 2'h2;
    localparam logic [1:0] SEL_PULSE = 2'h3;
    // Input selector code for the soft kick
    localparam logic [2:0] EVENT_SOFT = 3'h7;
    // Unit states
    typedef enum logic [1:0] {
        PTD_IDLE = 2'b01,
        PTD_RUN  = 2'b10
    } ptd_state_t;
endpackage

// ---- hdl/ptd_prescale.sv ----
// Module: prescale divider producing a tick every 1..128 bus clocks
`timescale 1ns/100ps
`default_nettype none
module ptd_prescale
(
    // Clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       RST_N,
    // Control
    input  wire logic       CLEAR,
    input  wire logic [2:0] CODE,
    // Tick out
    output logic            TICK
);
    logic [6:0] div_cnt;
    logic [6:0] div_last;

    // Terminal count is two to the power of the code, minus one
    assign div_last = 7'((8'h01 << CODE) - 8'h01); // RULE_01
    assign TICK     = (div_cnt == div_last);

    // Divider restarts with the counter so delays line up with the event
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N || CLEAR || TICK)
            div_cnt <= 7'h00;
        else
            div_cnt <= 7'(div_cnt + 7'h01);
    end
endmodule // ptd_prescale
`default_nettype wire

// ---- hdl/ptd_top.sv ----
// Module: programmable trigger delay unit with classic Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
module ptd_top
(
    // Clock and device reset
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [4:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    // Input event sources
    input  wire logic        COMPARATOR0_RESULT,
    input  wire logic        COMPARATOR1_RESULT,
    input  wire logic        COMPARATOR2_RESULT,
    input  wire logic        PWM_SYNC,
    input  wire logic        PIN_EVENT,
    input  wire logic        TIMER0_OUT,
    input  wire logic        TIMER1_OUT,
    // Output triggers
    output logic             FIRST_OUTPUT_EVENT,
    output logic             SECOND_OUTPUT_EVENT,
    output logic             FIRST_EARLY_EVENT,
    output logic             SECOND_EARLY_EVENT
);
    import ptd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [15:0] ctrl;
    logic [15:0] first_delay_value;
    logic [15:0] second_delay_value;
    logic [15:0] counter_period;
    logic [15:0] counter_value;
    logic        soft_kick;
    logic        shaped_pulse;
    ptd_state_t  state;

    logic [2:0]  prescale_code;
    logic [1:0]  first_output_select;
    logic [1:0]  second_output_select;
    logic        repeat_mode;
    logic [2:0]  input_event_select;
    logic        first_output_enable;
    logic        second_output_enable;
    logic        unit_on;

    assign prescale_code        = ctrl[PRESCALE_LSB +: 3];
    assign first_output_select  = ctrl[FIRST_SEL_LSB +: 2];
    assign second_output_select = ctrl[SECOND_SEL_LSB +: 2];
    assign repeat_mode          = ctrl[REPEAT_BIT];
    assign input_event_select   = ctrl[EVENT_SEL_LSB +: 3];
    assign first_output_enable  = ctrl[FIRST_EN_BIT];
    assign second_output_enable = ctrl[SECOND_EN_BIT];
    // Counter runs if either output is enabled
    assign unit_on = first_output_enable | second_output_enable; // RULE_11

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone decode: one wait state, ack drops the cycle after it is given
    logic       bus_req;
    logic       bus_wr;
    logic [2:0] reg_idx;
    logic       idx_hit;

    assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign bus_wr  = bus_req & WB_WE_I;
    assign reg_idx = WB_ADR_I[4:2];
    assign idx_hit = (reg_idx <= REG_COUNT_IDX);

    // Merge a write into a 16-bit register with byte enables
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
        logic [15:0] res;
        res = old;
        if (sel[0])
            res[7:0] = wdat[7:0];
        if (sel[1])
            res[15:8] = wdat[15:8];
        return res;
    endfunction

    // Acknowledge every access, mapped or not, one cycle after the request
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            WB_ACK_O <= 1'b0;
        else
            WB_ACK_O <= bus_req;
    end

    // Read data; kick bit and reserved bits read zero, count is live
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            WB_DAT_O <= 32'h00000000;
        else if (bus_req && !WB_WE_I)
        begin
            case (reg_idx)
                REG_CTRL_IDX:   WB_DAT_O <= {16'h0000, ctrl}; // RULE_07
                REG_DELAYA_IDX: WB_DAT_O <= {16'h0000, first_delay_value};
                REG_DELAYB_IDX: WB_DAT_O <= {16'h0000, second_delay_value};
                REG_PERIOD_IDX: WB_DAT_O <= {16'h0000, counter_period};
                REG_COUNT_IDX:  WB_DAT_O <= {16'h0000, counter_value}; // RULE_15
                default:        WB_DAT_O <= 32'h00000000;
            endcase
        end
    end

    // Control register; kick bit is not stored, only pulsed
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            ctrl <= REG_RESET; // RULE_27
        else if (bus_wr && idx_hit && reg_idx == REG_CTRL_IDX)
            ctrl <= merge16(ctrl, WB_DAT_I, WB_SEL_I) & CTRL_RW_MASK; // RULE_21
    end

    // Soft kick one-cycle strobe from a write of one
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            soft_kick <= 1'b0;
        else
            soft_kick <= bus_wr && reg_idx == REG_CTRL_IDX && WB_SEL_I[0]
                         && WB_DAT_I[KICK_BIT];
    end

    // Delay and period registers; count register ignores writes
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            first_delay_value  <= REG_RESET;
            second_delay_value <= REG_RESET;
            counter_period     <= REG_RESET;
        end
        else if (bus_wr)
        begin
            if (reg_idx == REG_DELAYA_IDX)
                first_delay_value <= merge16(first_delay_value, WB_DAT_I, WB_SEL_I);
            if (reg_idx == REG_DELAYB_IDX)
                second_delay_value <= merge16(second_delay_value, WB_DAT_I, WB_SEL_I);
            if (reg_idx == REG_PERIOD_IDX)
                counter_period <= merge16(counter_period, WB_DAT_I, WB_SEL_I);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input event selection and edge detection
    logic       event_mux;
    logic       event_prev;
    logic       hw_edge;
    logic       start;

    // Sources are synchronous; a sync pulse from a 3x domain is assumed
    // stretched to at least one bus clock, so a registered edge catches it
    always_comb
    begin
        case (input_event_select) // RULE_08
            3'h0:    event_mux = COMPARATOR0_RESULT;
            3'h1:    event_mux = COMPARATOR1_RESULT;
            3'h2:    event_mux = COMPARATOR2_RESULT;
            3'h3:    event_mux = PWM_SYNC; // RULE_18
            3'h4:    event_mux = PIN_EVENT;
            3'h5:    event_mux = TIMER0_OUT;
            3'h6:    event_mux = TIMER1_OUT;
            default: event_mux = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            event_prev <= 1'b0;
        else
            event_prev <= event_mux;
    end

    assign hw_edge = event_mux & ~event_prev; // RULE_22
    assign start   = unit_on & (hw_edge |
                     (soft_kick & (input_event_select == EVENT_SOFT))); // RULE_05

    ////////////////////////////////////////////////////////////////////////////
    // Prescaled counter
    logic tick;
    logic wrap;

    ptd_prescale u_prescale
    (
        .REF_CLK (REF_CLK),
        .RST_N   (RST_N),
        .CLEAR   (start || state != PTD_RUN),
        .CODE    (prescale_code),
        .TICK    (tick)
    );

    assign wrap = tick && (counter_value == counter_period);

    logic fresh;

    // First clock of each count value; matching here and not on the tick
    // that leaves the value keeps the early event at divisor*delay+1 clocks
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            fresh <= 1'b0;
        else
            fresh <= start || (state == PTD_RUN && tick); // RULE_23
    end

    // Run state: start or restart from zero, stop after wrap in one-shot
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            state <= PTD_IDLE;
        else if (!unit_on)
            state <= PTD_IDLE;
        else
        begin
            case (state)
                PTD_IDLE:
                    if (start)
                        state <= PTD_RUN;
                PTD_RUN:
                    if (!start && wrap && !repeat_mode) // RULE_04
                        state <= PTD_IDLE; // RULE_24
                default:
                    state <= PTD_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N || !unit_on)
            counter_value <= 16'h0000;
        else if (start)
            counter_value <= 16'h0000; // RULE_16
        else if (state == PTD_RUN && tick)
        begin
            if (wrap)
                counter_value <= 16'h0000; // RULE_14
            else
                counter_value <= 16'(counter_value + 16'h0001);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delay comparators and output shaping
    logic match_a;
    logic match_b;
    logic fire_a;
    logic fire_b;

    // A match fires once per count value, on its first clock
    assign match_a = first_output_enable && state == PTD_RUN
                     && counter_value == first_delay_value && fresh; // RULE_09
    assign match_b = second_output_enable && state == PTD_RUN
                     && counter_value == second_delay_value && fresh; // RULE_10

    // Early events register the matches; outputs follow one clock later
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            fire_a <= 1'b0;
            fire_b <= 1'b0;
        end
        else
        begin
            fire_a <= match_a; // RULE_23
            fire_b <= match_b;
        end
    end

    assign FIRST_EARLY_EVENT  = fire_a;
    assign SECOND_EARLY_EVENT = fire_b;

    // Pulse rises on the first early event and falls on the second;
    // a restart begins low so a level left by an earlier run is dropped
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N || !unit_on)
            shaped_pulse <= 1'b0;
        else if (fire_b)
            shaped_pulse <= 1'b0; // RULE_25
        else if (start)
            shaped_pulse <= 1'b0;
        else if (fire_a)
            shaped_pulse <= 1'b1;
    end

    // Output mux as a function; both outputs share the same encoding
    function automatic logic out_next(input logic [1:0] osel, input logic en,
                                      input logic bypass_ev, input logic a,
                                      input logic b, input logic pulse);
        logic r;
        r = 1'b0;
        if (en)
        begin
            case (osel)
                SEL_BYPASS:  r = bypass_ev; // RULE_06
                SEL_DELAY_A: r = a; // RULE_13
                SEL_BOTH:    r = a | b; // RULE_26
                SEL_PULSE:   r = pulse;
                default:     r = 1'b0;
            endcase
        end
        return r;
    endfunction

    logic bypass_ev;
    // Bypass passes the raw input edge or soft kick, one cycle wide
    assign bypass_ev = hw_edge | soft_kick;

    // Outputs from flip-flops so they never glitch
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            FIRST_OUTPUT_EVENT  <= 1'b0;
            SECOND_OUTPUT_EVENT <= 1'b0;
        end
        else
        begin
            FIRST_OUTPUT_EVENT <= out_next(first_output_select, first_output_enable,
                                           bypass_ev, fire_a, fire_b,
                                           shaped_pulse); // RULE_17 RULE_02
            SECOND_OUTPUT_EVENT <= out_next(second_output_select, second_output_enable,
                                            bypass_ev, fire_a, fire_b,
                                            shaped_pulse); // RULE_03
        end
    end
    // No interrupt logic exists in this unit // RULE_20
endmodule // ptd_top
`default_nettype wire

// ---- verification/ptd_checker.sv ----
// Checker: timing relations seen at the trigger delay unit ports
`timescale 1ns/100ps
`default_nettype none
module ptd_checker
(
    // Clock, reset and bus
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [4:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // Triggers
    input wire logic        FIRST_OUTPUT_EVENT,
    input wire logic        SECOND_OUTPUT_EVENT,
    input wire logic        FIRST_EARLY_EVENT,
    input wire logic        SECOND_EARLY_EVENT
);
    import ptd_pkg::*;
    logic [15:0] ctl;
    logic        tk;
    logic        wc;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////////
    // Taken transfer and taken full-width control write
    assign tk = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wc = tk && WB_WE_I && WB_ADR_I[4:2] == REG_CTRL_IDX && WB_SEL_I[1:0] == 2'h3;
    // Control shadow; partial writes are not tracked, the bench never makes them
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            ctl <= REG_RESET;
        else if (wc)
            ctl <= WB_DAT_I[15:0] & CTRL_RW_MASK;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Enables, delayed outputs and register reads
    first_off_a: assert property ((!ctl[1]) [*3] |-> !FIRST_OUTPUT_EVENT)
        else $error("first output high while disabled");
    second_off_a: assert property ((!ctl[0]) [*3] |-> !SECOND_OUTPUT_EVENT)
        else $error("second output high while disabled");
    idle_quiet_a: assert property ((ctl[1:0] == 2'h0) [*3] |-> !FIRST_EARLY_EVENT && !SECOND_EARLY_EVENT)
        else $error("early event while both disabled");
    early_lead_a: assert property (FIRST_EARLY_EVENT && ctl[1] && ctl[11:10] == SEL_DELAY_A
        |=> FIRST_OUTPUT_EVENT) else $error("output did not follow early event");
    single_wide_a: assert property (FIRST_OUTPUT_EVENT && ctl[11:10] == SEL_DELAY_A
        |=> !FIRST_OUTPUT_EVENT) else $error("delayed output wider than one cycle");
    both_or_a: assert property (SECOND_EARLY_EVENT && ctl[1] && ctl[11:10] == SEL_BOTH
        |=> FIRST_OUTPUT_EVENT) else $error("second delay missing on first output");
    pulse_rise_a: assert property (ctl[11:10] == SEL_PULSE && $rose(FIRST_OUTPUT_EVENT)
        |-> $past(FIRST_EARLY_EVENT, 2)) else $error("shaped pulse rose without early event");
    bypass_kick_a: assert property (wc && WB_DAT_I[5] && WB_DAT_I[11:10] == 2'h0 && WB_DAT_I[1]
        |-> ##[1:4] FIRST_OUTPUT_EVENT ##1 !FIRST_OUTPUT_EVENT) else $error("bypass kick lost");
    ctrl_read_a: assert property (tk && !WB_WE_I && WB_ADR_I[4:2] == REG_CTRL_IDX
        |=> WB_ACK_O && WB_DAT_O == {16'h0000, ctl}) else $error("control read mismatch");
endmodule // ptd_checker
bind ptd_top ptd_checker u_chk
(
    .REF_CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .FIRST_OUTPUT_EVENT, .SECOND_OUTPUT_EVENT, .FIRST_EARLY_EVENT,
    .SECOND_EARLY_EVENT
);
`default_nettype wire

// ---- verification/ptd_event_src.sv ----
// Partner model: event sources feeding the trigger delay unit
`timescale 1ns/100ps
`default_nettype none
module ptd_event_src
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Request from the bench
    input wire logic        fire,
    input wire logic [2:0]  line,
    // Event lines, index equals input selector code
    output logic     [6:0]  events
);
    logic [1:0] hold;
    ////////////////////////////////////////////////////////////////////////////
    // Two-clock pulse: a sync from a fast domain is stretched so it is not missed
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            hold <= 2'h0;
        else if (fire)
            hold <= 2'h2;
        else if (hold != 2'h0)
            hold <= hold - 2'h1;
    end
    // Drive only the requested line; code 7 has no line
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            events <= 7'h00;
        else if (fire)
            events <= 7'h01 << line;
        else if (hold == 2'h1)
            events <= 7'h00;
    end
endmodule // ptd_event_src
`default_nettype wire

// ---- verification/ptd_top_tb.sv ----
// Testbench: register and trigger timing scenarios for the trigger delay unit
`timescale 1ns/100ps
`default_nettype none
module ptd_top_tb;
    import ptd_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        fire = 1'b0;
    logic [2:0]  line = 3'h0;
    logic [6:0]  ev;
    logic        oa, ob, ea, eb;
    logic [31:0] q;
    int          errors = 0;
    int          cmp_count = 0;
    int          ta, to, tbb, na, nb, nea;
    ////////////////////////////////////////////////////////////////////////////
    // Clock, design and event sources
    always #5 clk = ~clk;
    ptd_top u_dut
    (
        .REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .COMPARATOR0_RESULT(ev[0]), .COMPARATOR1_RESULT(ev[1]), .COMPARATOR2_RESULT(ev[2]),
        .PWM_SYNC(ev[3]), .PIN_EVENT(ev[4]), .TIMER0_OUT(ev[5]), .TIMER1_OUT(ev[6]),
        .FIRST_OUTPUT_EVENT(oa), .SECOND_OUTPUT_EVENT(ob),
        .FIRST_EARLY_EVENT(ea), .SECOND_EARLY_EVENT(eb)
    );
    ptd_event_src u_src (.clk(clk), .rst_n(rst_n), .fire(fire), .line(line), .events(ev));
    ////////////////////////////////////////////////////////////////////////////
    // Verdict and comparison
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %0h seen %0h", s, exp, seen);
        end
    endtask
    // Classic cycle: hold until ack is sampled, take data there, then release
    task automatic wb(input logic w, input logic [2:0] i, input logic [15:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'h0};
        wdat <= {16'h0000, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1)
        begin
            errors++;
            stop_test();
        end
    endtask
    task automatic setd(input logic [15:0] a, input logic [15:0] b, input logic [15:0] m);
        wb(1'b1, REG_DELAYA_IDX, a);
        wb(1'b1, REG_DELAYB_IDX, b);
        wb(1'b1, REG_PERIOD_IDX, m);
    endtask
    task automatic kick_line(input logic [2:0] l);
        @(posedge clk);
        fire <= 1'b1;
        line <= l;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    // Record first early and output cycles and count high cycles of outputs;
    // sampling starts in the call's own cycle so a bypass pulse is not missed
    task automatic watch(input int n);
        ta = -1;
        to = -1;
        tbb = -1;
        na = 0;
        nb = 0;
        nea = 0;
        for (int i = 1; i <= n; i++)
        begin
            #1;
            if (ea === 1'b1 && ta < 0) ta = i;
            if (oa === 1'b1 && to < 0) to = i;
            if (eb === 1'b1 && tbb < 0) tbb = i;
            na += (oa === 1'b1);
            nb += (ob === 1'b1);
            nea += (ea === 1'b1);
            @(posedge clk);
        end
    endtask
    function automatic logic [15:0] ctl(input logic [2:0] p, input logic [1:0] a,
                                        input logic [1:0] b, input logic [6:0] r);
        return {p, 1'b0, a, 1'b0, b, r};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            wb(1'b0, i[2:0], 16'h0000);
            check("reset value", q, 32'h0);
        end
        wb(1'b1, REG_COUNT_IDX, 16'hFFFF);
        wb(1'b0, REG_COUNT_IDX, 16'h0000);
        check("count write", q, 32'h0);
        wb(1'b1, 3'h5, 16'hFFFF);
        wb(1'b0, 3'h5, 16'h0000);
        check("unmapped", q, 32'h0);
        wb(1'b1, REG_CTRL_IDX, 16'hFFFF);
        wb(1'b0, REG_CTRL_IDX, 16'h0000);
        check("control mask", q, {16'h0000, CTRL_RW_MASK});
        wb(1'b1, REG_CTRL_IDX, 16'h0000);
        for (int i = 1; i < 4; i++)
        begin
            wb(1'b1, i[2:0], 16'hA5C3);
            wb(1'b0, i[2:0], 16'h0000);
            check("value register", q, 32'h0000A5C3);
        end
        $display("Test registers done");
        // Divide by one gives the finest delay step
        setd(16'h0002, 16'h0007, 16'h0020);
        for (int s = 0; s < 7; s++)
        begin
            wb(1'b1, REG_CTRL_IDX, ctl(3'h0, SEL_DELAY_A, SEL_BYPASS, {2'h0, s[2:0], 2'h2}));
            kick_line(s[2:0]);
            watch(12);
            check("early time", ta, 5);
            check("output lag", to, 6);
            check("output pulses", na, 1);
            check("second held", nb, 0);
        end
        $display("Test selectors done");
        setd(16'h0014, 16'h0030, 16'h0040);
        wb(1'b1, REG_CTRL_IDX, ctl(3'h0, SEL_DELAY_A, SEL_BYPASS, 7'h12));
        kick_line(3'h4);
        watch(8);
        wb(1'b0, REG_COUNT_IDX, 16'h0000);
        check("live count", q[15:0] != 16'h0000, 1);
        kick_line(3'h4);
        watch(30);
        check("restart time", ta, 23);
        check("restart early", nea, 1);
        $display("Test restart done");
        setd(16'h0001, 16'h0002, 16'h0004);
        for (int c = 0; c < 2; c++)
        begin
            wb(1'b1, REG_CTRL_IDX, ctl(3'h0, SEL_DELAY_A, SEL_BYPASS, {c[0], 6'h3E}));
            watch(60);
            check("repeat", nea > 1, c[0]);
            check("kick start", nea > 0, 1);
        end
        $display("Test modes done");
        wb(1'b1, REG_CTRL_IDX, 16'h0000);
        setd(16'h0001, 16'h0002, 16'h0003);
        for (int p = 0; p < 8; p++)
        begin
            wb(1'b1, REG_CTRL_IDX, ctl(p[2:0], SEL_BOTH, SEL_BYPASS, 7'h3F));
            watch(300);
            check("divisor", tbb - ta, 1 << p);
            check("early delay", ta, (1 << p) + 2);
            check("both delays", na, 2);
            check("bypass kick", nb, 1);
        end
        $display("Test prescale done");
        for (int e = 1; e < 3; e++)
        begin
            wb(1'b1, REG_CTRL_IDX, ctl(3'h0, SEL_BYPASS, SEL_BYPASS, {5'h0F, e[1:0]}));
            watch(10);
            check("first enable", na, e >> 1);
            check("second enable", nb, e & 1);
        end
        // Disable first so a pulse level left by delay-only use is cleared
        wb(1'b1, REG_CTRL_IDX, 16'h0000);
        setd(16'h0002, 16'h0006, 16'h0010);
        wb(1'b1, REG_CTRL_IDX, ctl(3'h0, SEL_PULSE, SEL_PULSE, 7'h3F));
        watch(20);
        check("shaped width", na, 4);
        check("second shaped", nb, 4);
        wb(1'b1, REG_CTRL_IDX, ctl(3'h0, SEL_DELAY_A, SEL_DELAY_A, 7'h10));
        kick_line(3'h4);
        watch(20);
        check("disabled early", nea, 0);
        wb(1'b0, REG_COUNT_IDX, 16'h0000);
        check("disabled count", q, 32'h0);
        $display("Test enables done");
        stop_test();
    end
endmodule // ptd_top_tb
`default_nettype wire
